//--- shared/pspc_consts.svh
// Register offsets, field positions, reset values and codes of the port standby and pull control.
// Assumes a 32-bit APB slave with byte addresses; included by bare name.
`ifndef PSPC_CONSTS_SVH
`define PSPC_CONSTS_SVH

// =====================================================================
// Register byte offsets
`define PSPC_OFS_SYSCTL2   12'h000
`define PSPC_OFS_DIR       12'h004
`define PSPC_OFS_DATA      12'h008
`define PSPC_OFS_PINS      12'h00c
`define PSPC_OFS_STATUS    12'h010

// =====================================================================
// Field positions in system_control_two
`define PSPC_HMODE_LO      0
`define PSPC_HMODE_HI      1
`define PSPC_STANDBY_PIN_DRIVE_ENABLE_BIT      2
`define PSPC_HALT_BIT      3
`define PSPC_SYSCTL2_W     4

// =====================================================================
// Codes and reset values
`define PSPC_HMODE_STANDBY 2'h1
`define PSPC_SYSCTL2_RST   4'h0
`define PSPC_DIR_RST       8'h00
`define PSPC_DATA_RST      8'h00
`define PSPC_PORT_W        8

`endif

//--- shared/pspc_pkg.sv
// Types shared by the port standby and pull control.
// Assumes pspc_consts.svh is on the include path.
`include "pspc_consts.svh"

package pspc_pkg;

   // =====================================================================
   // Port-wide and bus-wide types
   typedef logic [`PSPC_PORT_W-1:0] pspc_port_t;
   typedef logic [31:0]             pspc_word_t;
   typedef logic [11:0]             pspc_addr_t;

endpackage

//--- core/pspc_pad_ctrl.sv
// Per-pin pad control: output drive, output enable, pull switch and input gating.
// Assumes all inputs are on ref_clk already; the caller registers the results.
`timescale 1ns/1ps
`include "pspc_consts.svh"

module pspc_pad_ctrl (
   input  wire pspc_pkg::pspc_port_t dirOut,
   input  wire pspc_pkg::pspc_port_t portData,
   input  wire pspc_pkg::pspc_port_t pinSync,
   input  wire logic                 standby,
   output logic [`PSPC_PORT_W-1:0]   padOutNxt,
   output logic [`PSPC_PORT_W-1:0]   padOeNxt,
   output logic [`PSPC_PORT_W-1:0]   pullEnNxt,
   output logic [`PSPC_PORT_W-1:0]   pinGated
);

   // =====================================================================
   // Pin slices
   genvar i;
   generate
      for (i = 0; i < `PSPC_PORT_W; i = i + 1) begin : gPin
         // Drivers are released in standby so no pin sources current.
         assign padOeNxt[i]  = dirOut[i] & ~standby;                 // [RULE7]
         assign padOutNxt[i] = dirOut[i] & portData[i] & ~standby;   // [RULE7]
         // An input pin takes its pull switch from its data bit; an output pin never pulls.
         assign pullEnNxt[i] = ~dirOut[i] & portData[i];             // [RULE3] [RULE4]
         // Input buffers are gated to 0 so floating pins draw nothing in standby.
         assign pinGated[i]  = pinSync[i] & ~standby;                // [RULE7]
      end
   endgenerate

endmodule

//--- core/pspc_top.sv
// Port standby and pull control: APB register file, standby gating and pad control.
// Assumes an APB master on ref_clk and pads with separate out, enable, pull and in signals.
//
// Functional notes
// RULE1: Standby gate goes high when halt set, mode field 01, drive-enable clear.
// RULE2: Drive-enable set forces standby gate to 0 whatever halt and mode hold.
// RULE3: Pull resistor is software switchable only while the pin is an input.
// RULE4: For an input pin the port data bit switches its pull resistor.
// RULE5: Software must not read-modify-write the port data register.
// RULE6: Undefined register bits read undefined; this design returns zero there.
// RULE7: In standby, output drivers are released and input buffers are gated.
`timescale 1ns/1ps
`include "pspc_consts.svh"

module pspc_top (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire pspc_pkg::pspc_addr_t paddr,
   input  wire pspc_pkg::pspc_word_t pwdata,
   input  wire logic [3:0]           pstrb,
   output pspc_pkg::pspc_word_t      prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire pspc_pkg::pspc_port_t padIn,
   input  wire logic                 wakeReq,
   output pspc_pkg::pspc_port_t      padOut,
   output pspc_pkg::pspc_port_t      padOe,
   output pspc_pkg::pspc_port_t      pullEn,
   output logic                      standbyGate
);

   // =====================================================================
   // Register map
   // Offset 0x000 is system_control_two: [1:0] halt_mode_select, [2] standby_pin_drive_enable, [3] halt.
   // Offset 0x004 is the direction register, one bit per pin, where 1 makes the pin an output.
   // Offset 0x008 is port_four_data: output level of output pins, pull switch of input pins.
   // Offset 0x00c returns the synchronised pin levels, which read as 0 during standby.
   // Offset 0x010 is the status word: [0] standby gate, [1] halt.
   // Every field sits in byte 0, so only byte lane 0 is honoured on writes.
   // Upper bits of every word read as zero.

   // =====================================================================
   // Bus timing
   // A request is taken on its first access edge, and pready follows one edge later.
   // Each transfer therefore costs a setup, an access and one wait cycle.
   // The wait state keeps the answer registered at the price of one cycle per transfer.
   // The bus cannot stop a read-modify-write of the data register; software must write it whole.

   // =====================================================================
   // Register state
   logic [`PSPC_SYSCTL2_W-1:0] sysCtl_r;
   logic [`PSPC_SYSCTL2_W-1:0] sysCtl_nxt;
   pspc_pkg::pspc_port_t       dir_r;
   pspc_pkg::pspc_port_t       dir_nxt;
   pspc_pkg::pspc_port_t       data_r;
   pspc_pkg::pspc_port_t       data_nxt;
   pspc_pkg::pspc_word_t       prdata_r;
   pspc_pkg::pspc_word_t       prdata_nxt;
   logic                       pready_r;
   logic                       pslverr_r;
   logic                       pslverr_nxt;
   logic                       standby_r;
   logic                       standby_nxt;
   pspc_pkg::pspc_port_t       padOut_r;
   pspc_pkg::pspc_port_t       padOe_r;
   pspc_pkg::pspc_port_t       pullEn_r;

   // =====================================================================
   // Synchronisers for pins
   pspc_pkg::pspc_port_t pinMeta_r;
   pspc_pkg::pspc_port_t pinSync_r;
   logic                 wakeMeta_r;
   logic                 wakeSync_r;

   // Two flops per pin; only the second stage feeds any logic.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pinMeta_r  <= 8'h00;
         pinSync_r  <= 8'h00;
         wakeMeta_r <= 1'b0;
         wakeSync_r <= 1'b0;
      end else begin
         pinMeta_r  <= padIn;
         pinSync_r  <= pinMeta_r;
         wakeMeta_r <= wakeReq;
         wakeSync_r <= wakeMeta_r;
      end
   end

   // =====================================================================
   // APB decode
   function automatic logic pspc_hit(input pspc_pkg::pspc_addr_t a, input pspc_pkg::pspc_addr_t ofs);
      pspc_hit = (a == ofs);
   endfunction

   wire accessNow = psel & penable & ~pready_r;
   wire wrNow     = accessNow & pwrite;
   wire wrLane0   = wrNow & pstrb[0];
   wire hitSys    = pspc_hit(paddr, `PSPC_OFS_SYSCTL2);
   wire hitDir    = pspc_hit(paddr, `PSPC_OFS_DIR);
   wire hitData   = pspc_hit(paddr, `PSPC_OFS_DATA);
   wire hitPins   = pspc_hit(paddr, `PSPC_OFS_PINS);
   wire hitStat   = pspc_hit(paddr, `PSPC_OFS_STATUS);
   wire hitAny    = hitSys | hitDir | hitData | hitPins | hitStat;
   wire wrSys     = wrLane0 & hitSys;
   wire wrDir     = wrLane0 & hitDir;
   wire wrData    = wrLane0 & hitData;

   // =====================================================================
   // Pad control slice
   pspc_pkg::pspc_port_t padOutNxt;
   pspc_pkg::pspc_port_t padOeNxt;
   pspc_pkg::pspc_port_t pullEnNxt;
   pspc_pkg::pspc_port_t pinGated;

   pspc_pad_ctrl uPad (
      .dirOut    (dir_r),
      .portData  (data_r),
      .pinSync   (pinSync_r),
      .standby   (standby_r),
      .padOutNxt (padOutNxt),
      .padOeNxt  (padOeNxt),
      .pullEnNxt (pullEnNxt),
      .pinGated  (pinGated)
   );

   // =====================================================================
   // Next values of the control registers
   wire [1:0] hModeWr = pwdata[`PSPC_HMODE_HI:`PSPC_HMODE_LO];
   wire       drveWr  = pwdata[`PSPC_STANDBY_PIN_DRIVE_ENABLE_BIT];
   wire       haltWr  = pwdata[`PSPC_HALT_BIT];
   wire       haltSet = wrSys & haltWr;
   // A wake request ends halt; a halt set in the same cycle still wins.
   wire       haltNxt = haltSet | (sysCtl_r[`PSPC_HALT_BIT] & ~wakeSync_r & ~(wrSys & ~haltWr));

   assign sysCtl_nxt = wrSys ? {haltNxt, drveWr, hModeWr}
                             : {haltNxt, sysCtl_r[`PSPC_STANDBY_PIN_DRIVE_ENABLE_BIT:0]};
   assign dir_nxt    = wrDir ? pwdata[`PSPC_PORT_W-1:0] : dir_r;
   // The data register doubles as the pull switch of input pins, so a read-back
   // of gated pin levels written here would change pulls; software writes it whole.
   assign data_nxt   = wrData ? pwdata[`PSPC_PORT_W-1:0] : data_r;   // [RULE4]

   // =====================================================================
   // Standby gating
   // Formed from next register values so the gate follows a write by one edge.
   wire [1:0] hModeNxt = sysCtl_nxt[`PSPC_HMODE_HI:`PSPC_HMODE_LO];
   assign standby_nxt = sysCtl_nxt[`PSPC_HALT_BIT]
                      & (hModeNxt == `PSPC_HMODE_STANDBY)   // [RULE1]
                      & ~sysCtl_nxt[`PSPC_STANDBY_PIN_DRIVE_ENABLE_BIT];        // [RULE2]

   // =====================================================================
   // Read data and error answer
   wire [31:0] rdSys  = {28'h0000000, sysCtl_r};
   wire [31:0] rdDir  = {24'h000000, dir_r};
   wire [31:0] rdData = {24'h000000, data_r};
   wire [31:0] rdPins = {24'h000000, pinGated};
   wire [31:0] rdStat = {30'h0, sysCtl_r[`PSPC_HALT_BIT], standby_r};
   // Undefined bits and unmapped reads return zero, which software must not rely on.
   wire [31:0] rdMux  = hitSys  ? rdSys  :
                        hitDir  ? rdDir  :
                        hitData ? rdData :
                        hitPins ? rdPins :
                        hitStat ? rdStat : 32'h00000000;   // [RULE6]

   assign prdata_nxt  = (accessNow & ~pwrite) ? rdMux : prdata_r;
   assign pslverr_nxt = accessNow & ~hitAny;

   // =====================================================================
   // Control registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sysCtl_r <= `PSPC_SYSCTL2_RST;
         dir_r    <= `PSPC_DIR_RST;
         data_r   <= `PSPC_DATA_RST;
      end else begin
         sysCtl_r <= sysCtl_nxt;
         dir_r    <= dir_nxt;
         data_r   <= data_nxt;
      end
   end

   // =====================================================================
   // Bus answer: one wait state, so pready rises in the second access cycle.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prdata_r  <= 32'h00000000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= accessNow;
         pslverr_r <= pslverr_nxt;
      end
   end

   // =====================================================================
   // Pad and standby outputs, all registered.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         standby_r <= 1'b0;
         padOut_r  <= 8'h00;
         padOe_r   <= 8'h00;
         pullEn_r  <= 8'h00;
      end else begin
         standby_r <= standby_nxt;   // [RULE1] [RULE2]
         padOut_r  <= padOutNxt;     // [RULE7]
         padOe_r   <= padOeNxt;      // [RULE7]
         pullEn_r  <= pullEnNxt;     // [RULE3]
      end
   end

   // =====================================================================
   // Port outputs, each taken straight from its flip-flop.
   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign standbyGate = standby_r;
   assign padOut      = padOut_r;
   assign padOe       = padOe_r;
   assign pullEn      = pullEn_r;

endmodule

//--- verif/pspc_chk.sv
// Port checker of pspc_top, attached by bind.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps

// =====================================================================
// Checker
module pspc_chk (
   input wire logic                 ref_clk,
   input wire logic                 rst_n,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire pspc_pkg::pspc_addr_t paddr,
   input wire pspc_pkg::pspc_word_t pwdata,
   input wire logic [3:0]           pstrb,
   input wire pspc_pkg::pspc_word_t prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire pspc_pkg::pspc_port_t padOut,
   input wire pspc_pkg::pspc_port_t padOe,
   input wire pspc_pkg::pspc_port_t pullEn,
   input wire logic                 standbyGate
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // A control write is taken on the first access edge with its byte lane on.
   wire taken = psel && penable && !pready;
   wire ctlWr = taken && pwrite && paddr == 12'h000 && pstrb[0];
   rdy_once_a: assert property (taken |=> pready ##1 !pready)
      else $error("ready not a single pulse after access");
   err_rdy_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   gate_set_a: assert property (ctlWr |=> standbyGate ==
      ($past(pwdata[3]) && $past(pwdata[1:0]) == 2'h1 && !$past(pwdata[2])))
      else $error("standby gate wrong after control write");
   gate_standby_pin_drive_enable_a: assert property (ctlWr && pwdata[2] |=> !standbyGate)
      else $error("standby gate high with drive enable set");
   pad_off_a: assert property (standbyGate |=> padOe == 8'h00 && padOut == 8'h00)
      else $error("pins driven in standby");
   pull_in_a: assert property ((pullEn & padOe) == 8'h00)
      else $error("pull on at a driving pin");
   out_oe_a: assert property ((padOut & ~padOe) == 8'h00)
      else $error("output value on an undriven pin");
   cover property ($rose(standbyGate));
   cover property (pready && pslverr);
   cover property (pullEn != 8'h00 && padOe != 8'h00);
endmodule

bind pspc_top pspc_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .padOut(padOut), .padOe(padOe), .pullEn(pullEn), .standbyGate(standbyGate));

//--- verif/tb_port_standby_pull_control.sv
// Self-checking bench of pspc_top over APB with random port data.
// Assumes pspc_chk is compiled beside it and bound to the design.
`timescale 1ns/1ps
`include "pspc_consts.svh"

// =====================================================================
// Bench
module tb_port_standby_pull_control;
   logic                 ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                 wakeReq = 1'b0, pready, pslverr, standbyGate;
   logic [3:0]           pstrb = 4'hf;
   logic [33:0]          eNote, expQ[$];
   pspc_pkg::pspc_addr_t paddr = 12'h000;
   pspc_pkg::pspc_word_t pwdata = 32'h0, prdata;
   pspc_pkg::pspc_port_t padIn = 8'h00, padOut, padOe, pullEn, dirV, datV;
   int                   failCount = 0, checksDone = 0, cycles = 0, seed = 47;

   pspc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .padIn(padIn), .wakeReq(wakeReq), .padOut(padOut), .padOe(padOe), .pullEn(pullEn),
      .standbyGate(standbyGate));

   initial forever #10 ref_clk = ~ref_clk;

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // One transfer; the note is {read, error, data} and is held until ready.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
      expQ.push_back(e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {2'b10, d});
   endtask

   // The watcher pairs each ready pulse with the oldest note; write data is not compared.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 5000) begin
         failCount++;
         final_report();
      end else if (pready === 1'b1 && expQ.size() > 0) begin
         eNote = expQ.pop_front();
         check({1'b0, pslverr, eNote[33] ? prdata : 32'h0}, {1'b0, eNote[32:0]});
      end
   end

   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(`PSPC_OFS_SYSCTL2, 32'h0);
      rd(`PSPC_OFS_DIR, 32'h0);
      rd(`PSPC_OFS_STATUS, 32'h0);
      apb(1'b0, 12'h020, 32'h0, {2'b11, 32'h0});
      $display("test reset and unmapped done");
      dirV = 8'($random(seed));
      datV = 8'($random(seed));
      padIn <= 8'($random(seed));
      wr(`PSPC_OFS_DIR, {24'h0, dirV});
      wr(`PSPC_OFS_DATA, {24'h0, datV});
      repeat (2) @(posedge ref_clk);
      check({26'h0, padOe}, {26'h0, dirV});
      check({26'h0, padOut}, {26'h0, dirV & datV});
      check({26'h0, pullEn}, {26'h0, ~dirV & datV});
      rd(`PSPC_OFS_PINS, {24'h0, padIn});
      // A write with its byte lane off must leave the data register alone.
      pstrb <= 4'h0;
      wr(`PSPC_OFS_DATA, {24'h0, ~datV});
      pstrb <= 4'hf;
      rd(`PSPC_OFS_DATA, {24'h0, datV});
      $display("test pads and pulls done");
      for (int i = 8; i < 16; i++) begin
         wr(`PSPC_OFS_SYSCTL2, 32'(i));
         rd(`PSPC_OFS_STATUS, {30'h0, 1'b1, i[2:0] == 3'h1});
      end
      wr(`PSPC_OFS_SYSCTL2, 32'h9);
      repeat (2) @(posedge ref_clk);
      check({2'h0, padOe, padOut, pullEn, 8'h0}, {18'h0, ~dirV & datV, 8'h0});
      rd(`PSPC_OFS_PINS, 32'h0);
      wakeReq <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(`PSPC_OFS_STATUS, 32'h0);
      wakeReq <= 1'b0;
      $display("test standby done");
      // A second reset in mid-run must clear the data register and every pull.
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(`PSPC_OFS_DATA, 32'h0);
      check({26'h0, pullEn}, 34'h0);
      $display("test mid-run reset done");
      repeat (4) @(posedge ref_clk);
      final_report();
   end
endmodule
